/* inc/iag_params.svh */
// Constants for the indirect address generator: widths, reset values and cycle counts.
`ifndef IAG_PARAMS_SVH
`define IAG_PARAMS_SVH

// ==========================================================================
// Widths
`define IAG_W 16
`define IAG_SHORT_W 6
`define IAG_NUM_PTR 5

// ==========================================================================
// Reset values
`define IAG_PTR_RST 16'h0000
`define IAG_OFF_RST 16'h0000
`define IAG_MOD_RST 16'hFFFF

// ==========================================================================
// Modifier encodings
`define IAG_MOD_LINEAR 16'hFFFF
`define IAG_MOD_R0_ONLY_BIT 15

// ==========================================================================
// Extra instruction cycles per mode
`define IAG_EXTRA_NONE 2'h0
`define IAG_EXTRA_IDX_OFF 2'h1
`define IAG_EXTRA_SHORT 2'h1
`define IAG_EXTRA_LONG 2'h2

`endif

/* inc/iag_pkg.sv */
// Types shared by the indirect address generator modules.
`include "iag_params.svh"

package iag_pkg;

  // ========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    IAG_NO_UPD,
    IAG_POST_INC,
    IAG_POST_DEC,
    IAG_POST_UPD_OFF,
    IAG_IDX_OFF,
    IAG_IDX_SHORT,
    IAG_IDX_LONG
  } iag_mode_t;

  typedef enum logic [2:0] {
    IAG_PTR_ZERO,
    IAG_PTR_ONE,
    IAG_PTR_TWO,
    IAG_PTR_THREE,
    IAG_STACK_POINTER
  } iag_ptr_sel_t;

  typedef enum logic [2:0] {
    IAG_REG_PTR_ZERO,
    IAG_REG_PTR_ONE,
    IAG_REG_PTR_TWO,
    IAG_REG_PTR_THREE,
    IAG_REG_STACK_POINTER,
    IAG_REG_OFFSET,
    IAG_REG_MODIFIER
  } iag_reg_sel_t;

  typedef enum logic {
    IAG_SPACE_DATA,
    IAG_SPACE_PROG
  } iag_space_t;

  typedef enum logic [1:0] {
    IAG_SIZE_WORD,
    IAG_SIZE_BYTE,
    IAG_SIZE_LONG
  } iag_size_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    iag_space_t space;
    iag_mode_t mode;
    iag_ptr_sel_t ptr;
    iag_size_t size;
    logic dual_first;
    logic dual_second;
    logic shift_cnt;
    logic fetch_data;
    logic [`IAG_SHORT_W-1:0] disp_short;
    logic [`IAG_W-1:0] disp_long;
  } iag_req_t;

  typedef struct packed {
    logic [`IAG_W-1:0] ea;
    iag_space_t space;
    logic on_chip_only;
  } iag_rsp_t;

  typedef struct packed {
    logic [`IAG_NUM_PTR-1:0][`IAG_W-1:0] ptr;
    logic [`IAG_W-1:0] offset;
    logic [`IAG_W-1:0] modifier;
  } iag_regs_t;

endpackage

/* hw/iag_ptr_reg.sv */
// One address pointer register with a load port and an update port.
`timescale 1ns/1ns
`include "iag_params.svh"

module iag_ptr_reg import iag_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ld_en_in,
  input wire logic [`IAG_W-1:0] ld_data_in,
  input wire logic upd_en_in,
  input wire logic [`IAG_W-1:0] upd_data_in,
  output logic [`IAG_W-1:0] q_out
);

  // A direct load from the core wins over an address update in the same cycle.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_out <= `IAG_PTR_RST;
    end else if (ld_en_in) begin
      q_out <= ld_data_in;
    end else if (upd_en_in) begin
      q_out <= upd_data_in;
    end
  end

endmodule

/* hw/iag_mod_unit.sv */
// Linear or modulo adder for pointer plus step.
`timescale 1ns/1ns
`include "iag_params.svh"

module iag_mod_unit import iag_pkg::*; (
  input wire logic [`IAG_W-1:0] ptr_in,
  input wire logic [`IAG_W-1:0] step_in,
  input wire logic [`IAG_W-1:0] modifier_in,
  input wire logic mod_en_in,
  output logic [`IAG_W-1:0] result_out
);

  logic [`IAG_W-1:0] mask;
  logic [`IAG_W-1:0] lin;
  logic [`IAG_W:0] size;
  logic [`IAG_W:0] sum;
  logic [`IAG_W:0] wrapped;

  // The buffer base is aligned to the smallest power of two not below the modulus.
  // A step larger in magnitude than the modulus gives no defined result.
  always_comb begin
    mask = modifier_in;
    for (int i = 1; i < `IAG_W; i = i * 2) begin
      mask = mask | (mask >> i);
    end
    lin = ptr_in + step_in;
    size = {1'b0, modifier_in} + 17'h00001;
    sum = {1'b0, ptr_in & mask} + {step_in[`IAG_W-1], step_in};
    wrapped = sum;
    if (step_in[`IAG_W-1] && sum[`IAG_W]) begin
      wrapped = sum + size;
    end else if (!step_in[`IAG_W-1] && (sum > {1'b0, modifier_in})) begin
      wrapped = sum - size;
    end
    if (mod_en_in) begin
      result_out = (ptr_in & ~mask) | (wrapped[`IAG_W-1:0] & mask);
    end else begin
      result_out = lin;
    end
  end

endmodule

/* hw/iag_indirect_address_generator.sv */
// Effective-address generator for address-register-indirect operand modes.
`timescale 1ns/1ns
`include "iag_params.svh"

module iag_indirect_address_generator import iag_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire iag_req_t req_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic wr_en_in,
  input wire iag_reg_sel_t wr_sel_in,
  input wire logic [`IAG_W-1:0] wr_data_in,
  output iag_rsp_t rsp_out,
  output logic rsp_valid_out,
  output logic rej_out,
  output logic [`IAG_W-1:0] ptr_zero_out,
  output iag_regs_t regs_out
);

  // ========================================================================
  // Declarations
  typedef enum logic {
    IAG_ST_IDLE,
    IAG_ST_WAIT
  } iag_state_t;

  iag_state_t state_q;
  logic [1:0] wait_cnt_q;
  iag_rsp_t pend_q;
  logic [`IAG_W-1:0] offset_q;
  logic [`IAG_W-1:0] modifier_q;
  logic [`IAG_NUM_PTR-1:0][`IAG_W-1:0] ptr_val;
  logic [`IAG_NUM_PTR-1:0] ptr_ld;
  logic [`IAG_NUM_PTR-1:0] ptr_upd;
  logic [`IAG_W-1:0] cur_ptr;
  logic [`IAG_W-1:0] step;
  logic [`IAG_W-1:0] calc;
  logic [`IAG_W-1:0] ea;
  logic mod_en;
  logic is_general;
  logic upd_ptr;
  logic [1:0] extra;
  logic illegal;
  logic accept;
  iag_rsp_t rsp_d;

  // ========================================================================
  // Pointer registers
  // The stack pointer sits at the last index, so the general pointers are
  // exactly the low four entries.
  assign is_general = (req_in.ptr != IAG_STACK_POINTER);

  // Loads come from register-direct moves; updates come from accepted modes.
  always_comb begin
    ptr_ld = '0;
    ptr_upd = '0;
    if (wr_en_in && (wr_sel_in <= IAG_REG_STACK_POINTER)) begin
      ptr_ld[wr_sel_in[2:0]] = 1'b1;
    end
    if (accept && !illegal && upd_ptr) begin
      ptr_upd[req_in.ptr] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `IAG_NUM_PTR; gi = gi + 1) begin : g_ptr
      iag_ptr_reg u_ptr (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .ld_en_in(ptr_ld[gi]),
        .ld_data_in(wr_data_in),
        .upd_en_in(ptr_upd[gi]),
        .upd_data_in(calc),
        .q_out(ptr_val[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Shared offset register
  // One offset serves every pointer; no mode ever changes it.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      offset_q <= `IAG_OFF_RST;
    end else if (wr_en_in && (wr_sel_in == IAG_REG_OFFSET)) begin
      offset_q <= wr_data_in;
    end
  end

  // ========================================================================
  // Modifier register
  // All ones selects linear arithmetic, which is also the reset state.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      modifier_q <= `IAG_MOD_RST;
    end else if (wr_en_in && (wr_sel_in == IAG_REG_MODIFIER)) begin
      modifier_q <= wr_data_in;
    end
  end

  // ========================================================================
  // Arithmetic type
  // The type is decoded from the modifier contents at calculation time, so a
  // new modifier value takes effect on the next calculation without any
  // help from the instruction word. Pointer one opts out when the top bit of
  // a non-linear modifier is set, which lets pointer zero walk a circular
  // buffer while pointer one stays linear.
  always_comb begin
    mod_en = 1'b0;
    case (req_in.ptr)
      IAG_PTR_ZERO: begin
        mod_en = (modifier_q != `IAG_MOD_LINEAR);
      end
      IAG_PTR_ONE: begin
        mod_en = (modifier_q != `IAG_MOD_LINEAR) &&
                 !modifier_q[`IAG_MOD_R0_ONLY_BIT];
      end
      default: begin
        mod_en = 1'b0;
      end
    endcase
    if (req_in.mode == IAG_IDX_SHORT) begin
      mod_en = 1'b0;
    end
  end

  // ========================================================================
  // Step selection
  // The offset and the long displacement are two's-complement values, so a
  // plain sixteen-bit add wraps them correctly in linear mode.
  always_comb begin
    step = '0;
    case (req_in.mode)
      IAG_POST_INC: begin
        step = 16'h0001;
      end
      IAG_POST_DEC: begin
        step = 16'hFFFF;
      end
      IAG_POST_UPD_OFF, IAG_IDX_OFF: begin
        step = offset_q;
      end
      IAG_IDX_SHORT: begin
        if (req_in.ptr == IAG_STACK_POINTER) begin
          step = {10'h3FF, req_in.disp_short};
        end else begin
          step = {10'h000, req_in.disp_short};
        end
      end
      IAG_IDX_LONG: begin
        step = req_in.disp_long;
      end
      default: begin
        step = '0;
      end
    endcase
  end

  assign cur_ptr = ptr_val[req_in.ptr];

  // ========================================================================
  // Adder
  iag_mod_unit u_mod (
    .ptr_in(cur_ptr),
    .step_in(step),
    .modifier_in(modifier_q),
    .mod_en_in(mod_en),
    .result_out(calc)
  );

  // ========================================================================
  // Address, write-back and cycle cost per mode
  // Post modes use the old pointer and write the sum back; indexed modes use
  // the sum as the address and leave every register untouched.
  always_comb begin
    ea = cur_ptr;
    upd_ptr = 1'b0;
    extra = `IAG_EXTRA_NONE;
    case (req_in.mode)
      IAG_NO_UPD: begin
        ea = cur_ptr;
      end
      IAG_POST_INC, IAG_POST_DEC, IAG_POST_UPD_OFF: begin
        ea = cur_ptr;
        upd_ptr = 1'b1;
      end
      IAG_IDX_OFF: begin
        ea = calc;
        extra = `IAG_EXTRA_IDX_OFF;
      end
      IAG_IDX_SHORT: begin
        ea = calc;
        extra = `IAG_EXTRA_SHORT;
      end
      IAG_IDX_LONG: begin
        ea = calc;
        extra = `IAG_EXTRA_LONG;
      end
      default: begin
        ea = cur_ptr;
      end
    endcase
  end

  // ========================================================================
  // Legality checks
  // A rejected request changes no register and produces no address.
  always_comb begin
    illegal = 1'b0;
    if (req_in.ptr > IAG_STACK_POINTER) begin
      illegal = 1'b1;
    end
    if (req_in.mode > IAG_IDX_LONG) begin
      illegal = 1'b1;
    end
    if (req_in.space == IAG_SPACE_PROG) begin
      if (!((req_in.mode == IAG_POST_INC) || (req_in.mode == IAG_POST_UPD_OFF))) begin
        illegal = 1'b1;
      end
      if (!is_general || req_in.fetch_data) begin
        illegal = 1'b1;
      end
    end else if ((req_in.mode == IAG_POST_UPD_OFF) && (req_in.size != IAG_SIZE_WORD)) begin
      illegal = 1'b1;
    end
    if ((req_in.mode == IAG_IDX_SHORT) &&
        !((req_in.ptr == IAG_PTR_TWO) || (req_in.ptr == IAG_STACK_POINTER))) begin
      illegal = 1'b1;
    end
    if ((req_in.dual_first || req_in.dual_second) && (req_in.ptr == IAG_PTR_TWO)) begin
      illegal = 1'b1;
    end
    if (req_in.dual_second && (req_in.ptr != IAG_PTR_THREE)) begin
      illegal = 1'b1;
    end
    if (req_in.shift_cnt && (req_in.ptr != IAG_PTR_ZERO)) begin
      illegal = 1'b1;
    end
  end

  // ========================================================================
  // Handshake and answer
  // The second read of a dual read is marked on-chip only, so the memory
  // interface never routes it to the external bus.
  assign req_ready_out = (state_q == IAG_ST_IDLE);
  assign accept = req_valid_in && req_ready_out;

  always_comb begin
    rsp_d.ea = ea;
    rsp_d.space = req_in.space;
    rsp_d.on_chip_only = req_in.dual_second;
  end

  // ========================================================================
  // Sequencer
  // Indexed modes hold the address back for their extra cycles; the unit
  // stays busy meanwhile, which stalls the decoder through req_ready_out.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= IAG_ST_IDLE;
      wait_cnt_q <= 2'h0;
      pend_q <= '0;
    end else begin
      case (state_q)
        IAG_ST_IDLE: begin
          if (accept && !illegal && (extra != `IAG_EXTRA_NONE)) begin
            state_q <= IAG_ST_WAIT;
            wait_cnt_q <= extra;
            pend_q <= rsp_d;
          end
        end
        IAG_ST_WAIT: begin
          if (wait_cnt_q == 2'h1) begin
            state_q <= IAG_ST_IDLE;
          end
          wait_cnt_q <= wait_cnt_q - 2'h1;
        end
        default: begin
          state_q <= IAG_ST_IDLE;
        end
      endcase
    end
  end

  // Answer flops: one cycle after acceptance, or after the extra cycles.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_out <= '0;
      rsp_valid_out <= 1'b0;
      rej_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      rej_out <= accept && illegal;
      if (accept && !illegal && (extra == `IAG_EXTRA_NONE)) begin
        rsp_out <= rsp_d;
        rsp_valid_out <= 1'b1;
      end else if ((state_q == IAG_ST_WAIT) && (wait_cnt_q == 2'h1)) begin
        rsp_out <= pend_q;
        rsp_valid_out <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Register view
  // Pointer zero is brought out on its own for the shift count instruction
  // and as a conditional transfer source.
  assign ptr_zero_out = ptr_val[IAG_PTR_ZERO];

  always_comb begin
    regs_out.ptr = ptr_val;
    regs_out.offset = offset_q;
    regs_out.modifier = modifier_q;
  end

endmodule

/* dv/iag_dec_model.sv */
// Request issuer standing in for the core instruction decoder.
`timescale 1ns/1ns
`include "iag_params.svh"

module iag_dec_model import iag_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic req_ready_in,
  input wire logic rsp_valid_in,
  input wire logic rej_in,
  input wire iag_rsp_t rsp_in,
  output iag_req_t req_out,
  output logic req_valid_out
);
  // ==========================================================================
  // Issue
  // Lines start idle; a released request shows the inverse of its last value.
  initial begin
    req_out = '0;
    req_valid_out = 1'b0;
  end

  // Holds the request until ready is seen at a rising edge, then waits for the answer.
  task automatic issue(input iag_req_t r, output logic [`IAG_W-1:0] ea, output logic rj,
      output int lat);
    int n;
    n = 0;
    lat = 0;
    @(negedge ref_clk_in);
    req_out = r;
    req_valid_out = 1'b1;
    @(posedge ref_clk_in);
    while (!req_ready_in && n < 8) begin
      n++;
      @(posedge ref_clk_in);
    end
    do begin
      @(negedge ref_clk_in);
      req_valid_out = 1'b0;
      req_out = ~r;
      lat++;
    end while (!rsp_valid_in && !rej_in && lat < 6);
    ea = rsp_in.ea;
    rj = rej_in;
  endtask
endmodule

/* dv/iag_indirect_address_generator_sva.sv */
// Concurrent checks on the indirect address generator ports.
`timescale 1ns/1ns
`include "iag_params.svh"

module iag_indirect_address_generator_sva import iag_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire iag_req_t req_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic wr_en_in,
  input wire iag_reg_sel_t wr_sel_in,
  input wire logic [`IAG_W-1:0] wr_data_in,
  input wire iag_rsp_t rsp_out,
  input wire logic rsp_valid_out,
  input wire logic rej_out,
  input wire logic [`IAG_W-1:0] ptr_zero_out,
  input wire iag_regs_t regs_out
);
  // ==========================================================================
  // Helpers
  // A plain request is a word data access with no dual, shift or fetch flag.
  logic acc;
  logic plain;
  logic [`IAG_W-1:0] cur_ptr;
  assign acc = req_valid_in && req_ready_out && !wr_en_in;
  assign plain = req_in.space == IAG_SPACE_DATA && req_in.size == IAG_SIZE_WORD &&
      !req_in.dual_first && !req_in.dual_second && !req_in.shift_cnt && !req_in.fetch_data;
  assign cur_ptr = regs_out.ptr[req_in.ptr];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  // ==========================================================================
  // Assertions
  AST_NOUPD_EA: assert property (acc && plain && req_in.mode == IAG_NO_UPD |=>
      rsp_valid_out && rsp_out.ea == $past(cur_ptr)) else $error("no-update address wrong");
  AST_INC_LIN: assert property (acc && plain && req_in.mode == IAG_POST_INC &&
      req_in.ptr inside {IAG_PTR_TWO, IAG_PTR_THREE, IAG_STACK_POINTER} |=>
      regs_out.ptr[$past(req_in.ptr)] == $past(cur_ptr) + 16'h0001)
      else $error("linear increment wrong");
  AST_DEC_LIN: assert property (acc && plain && req_in.mode == IAG_POST_DEC &&
      req_in.ptr inside {IAG_PTR_TWO, IAG_PTR_THREE, IAG_STACK_POINTER} |=>
      regs_out.ptr[$past(req_in.ptr)] == $past(cur_ptr) - 16'h0001)
      else $error("linear decrement wrong");
  AST_IDX_LAT: assert property (acc && plain && req_in.mode == IAG_IDX_OFF |=>
      !req_ready_out && !rsp_valid_out ##1 rsp_valid_out) else $error("indexed latency wrong");
  AST_LONG_LAT: assert property (acc && plain && req_in.mode == IAG_IDX_LONG |=>
      (!req_ready_out && !rsp_valid_out) [*2] ##1 rsp_valid_out && req_ready_out)
      else $error("long displacement latency wrong");
  AST_SHORT_REJ: assert property (acc && req_in.mode == IAG_IDX_SHORT &&
      !(req_in.ptr inside {IAG_PTR_TWO, IAG_STACK_POINTER}) |=> rej_out && !rsp_valid_out)
      else $error("short displacement not refused");
  AST_DUAL_TWO: assert property (acc && req_in.ptr == IAG_PTR_TWO &&
      (req_in.dual_first || req_in.dual_second) |=> rej_out) else $error("dual on two kept");
  AST_ONCHIP: assert property (acc && req_in.dual_second &&
      req_in.ptr == IAG_PTR_THREE && req_in.space == IAG_SPACE_DATA &&
      req_in.mode == IAG_NO_UPD && !req_in.shift_cnt |=>
      rsp_valid_out && rsp_out.on_chip_only) else $error("second read not on chip");
  AST_PROG_REJ: assert property (acc && req_in.space == IAG_SPACE_PROG &&
      !(req_in.mode inside {IAG_POST_INC, IAG_POST_UPD_OFF}) |=> rej_out)
      else $error("program mode not refused");
  AST_SIZE_REJ: assert property (acc && req_in.space == IAG_SPACE_DATA &&
      req_in.mode == IAG_POST_UPD_OFF && req_in.size != IAG_SIZE_WORD |=> rej_out)
      else $error("sized offset update not refused");
  AST_SHIFT_REJ: assert property (acc && req_in.shift_cnt && req_in.ptr != IAG_PTR_ZERO
      |=> rej_out) else $error("shift count pointer not refused");
  AST_OFF_LOAD: assert property (wr_en_in && wr_sel_in == IAG_REG_OFFSET |=>
      regs_out.offset == $past(wr_data_in)) else $error("offset load lost");
endmodule

bind iag_indirect_address_generator iag_indirect_address_generator_sva chk_i (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .req_in(req_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in),
  .wr_data_in(wr_data_in), .rsp_out(rsp_out), .rsp_valid_out(rsp_valid_out),
  .rej_out(rej_out), .ptr_zero_out(ptr_zero_out), .regs_out(regs_out));

/* dv/iag_indirect_address_generator_tb.sv */
// Self-checking testbench for the indirect address generator.
`timescale 1ns/1ns
`include "iag_params.svh"

module iag_indirect_address_generator_tb import iag_pkg::*;;
  logic ref_clk_in;
  logic nrst_in;
  logic wr_en_in;
  iag_reg_sel_t wr_sel_in;
  logic [`IAG_W-1:0] wr_data_in;
  iag_req_t req_in;
  logic req_valid_in;
  logic req_ready_out;
  iag_rsp_t rsp_out;
  logic rsp_valid_out;
  logic rej_out;
  logic [`IAG_W-1:0] ptr_zero_out;
  iag_regs_t regs_out;
  int miscompares;
  int checks;

  iag_indirect_address_generator uut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .req_in(req_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in), .wr_data_in(wr_data_in), .rsp_out(rsp_out),
    .rsp_valid_out(rsp_valid_out), .rej_out(rej_out), .ptr_zero_out(ptr_zero_out),
    .regs_out(regs_out));

  iag_dec_model dec (.ref_clk_in(ref_clk_in), .req_ready_in(req_ready_out),
    .rsp_valid_in(rsp_valid_out), .rej_in(rej_out), .rsp_in(rsp_out), .req_out(req_in),
    .req_valid_out(req_valid_in));

  // ==========================================================================
  // Helpers
  // Free-running 25 MHz clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle register load, launched off the falling edge.
  task automatic load(input iag_reg_sel_t s, input logic [15:0] d);
    @(negedge ref_clk_in);
    wr_en_in = 1'b1;
    wr_sel_in = s;
    wr_data_in = d;
    @(negedge ref_clk_in);
    wr_en_in = 1'b0;
  endtask

  function automatic iag_req_t mk(iag_space_t s, iag_mode_t m, iag_ptr_sel_t p);
    iag_req_t r;
    r = '0;
    r.space = s;
    r.mode = m;
    r.ptr = p;
    return r;
  endfunction

  // Issues one request and judges refusal, address and answer latency.
  task automatic req(input iag_req_t r, input logic [15:0] e_ea, input logic e_rej,
      input int e_lat);
    logic [15:0] ea;
    logic rj;
    int lat;
    dec.issue(r, ea, rj, lat);
    chk("rej", {15'h0000, e_rej}, {15'h0000, rj});
    if (!e_rej) chk("ea", e_ea, ea);
    chk("latency", e_lat[15:0], lat[15:0]);
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 5; i++) chk("ptr rst", 16'h0000, regs_out.ptr[i]);
    chk("mod rst", 16'hFFFF, regs_out.modifier);
    nrst_in = 1'b1;
    $display("test reset done");
  endtask

  // Linear modes on pointer three with a shared offset; long indexing wraps at 16 bits.
  task automatic t_modes();
    iag_req_t r;
    load(IAG_REG_PTR_THREE, 16'h0100);
    load(IAG_REG_OFFSET, 16'h0010);
    req(mk(IAG_SPACE_DATA, IAG_NO_UPD, IAG_PTR_THREE), 16'h0100, 1'b0, 1);
    chk("ptr3", 16'h0100, regs_out.ptr[3]);
    req(mk(IAG_SPACE_DATA, IAG_POST_INC, IAG_PTR_THREE), 16'h0100, 1'b0, 1);
    req(mk(IAG_SPACE_DATA, IAG_POST_DEC, IAG_PTR_THREE), 16'h0101, 1'b0, 1);
    req(mk(IAG_SPACE_DATA, IAG_POST_UPD_OFF, IAG_PTR_THREE), 16'h0100, 1'b0, 1);
    req(mk(IAG_SPACE_DATA, IAG_IDX_OFF, IAG_PTR_THREE), 16'h0120, 1'b0, 2);
    chk("ptr3 idx", 16'h0110, regs_out.ptr[3]);
    r = mk(IAG_SPACE_DATA, IAG_IDX_LONG, IAG_PTR_THREE);
    r.disp_long = 16'hFF00;
    req(r, 16'h0010, 1'b0, 3);
    r.ptr = IAG_STACK_POINTER;
    r.disp_long = 16'h1234;
    req(r, 16'h1234, 1'b0, 3);
    $display("test modes done");
  endtask

  // Short displacement: one-extended below the stack pointer, zero-extended above two.
  task automatic t_short();
    iag_req_t r;
    load(IAG_REG_STACK_POINTER, 16'h0050);
    load(IAG_REG_PTR_TWO, 16'h0010);
    r = mk(IAG_SPACE_DATA, IAG_IDX_SHORT, IAG_STACK_POINTER);
    r.disp_short = 6'h02;
    req(r, 16'h0012, 1'b0, 2);
    r.ptr = IAG_PTR_TWO;
    r.disp_short = 6'h3F;
    req(r, 16'h004F, 1'b0, 2);
    r.ptr = IAG_PTR_ZERO;
    req(r, 16'h0000, 1'b1, 1);
    $display("test short done");
  endtask

  // Modulo eight on pointers zero and one; bit 15 of the modifier frees pointer one.
  task automatic t_modulo();
    load(IAG_REG_MODIFIER, 16'h0007);
    load(IAG_REG_PTR_ZERO, 16'h0007);
    load(IAG_REG_PTR_ONE, 16'h0007);
    load(IAG_REG_PTR_TWO, 16'h0007);
    load(IAG_REG_OFFSET, 16'h0003);
    req(mk(IAG_SPACE_DATA, IAG_POST_INC, IAG_PTR_ZERO), 16'h0007, 1'b0, 1);
    chk("ptr0 wrap", 16'h0000, ptr_zero_out);
    req(mk(IAG_SPACE_DATA, IAG_POST_DEC, IAG_PTR_ZERO), 16'h0000, 1'b0, 1);
    chk("ptr0 back", 16'h0007, regs_out.ptr[0]);
    req(mk(IAG_SPACE_DATA, IAG_POST_UPD_OFF, IAG_PTR_ZERO), 16'h0007, 1'b0, 1);
    chk("ptr0 off", 16'h0002, regs_out.ptr[0]);
    req(mk(IAG_SPACE_DATA, IAG_POST_INC, IAG_PTR_ONE), 16'h0007, 1'b0, 1);
    chk("ptr1 mod", 16'h0000, regs_out.ptr[1]);
    req(mk(IAG_SPACE_DATA, IAG_POST_INC, IAG_PTR_TWO), 16'h0007, 1'b0, 1);
    chk("ptr2 lin", 16'h0008, regs_out.ptr[2]);
    load(IAG_REG_MODIFIER, 16'h8007);
    load(IAG_REG_PTR_ONE, 16'h0007);
    req(mk(IAG_SPACE_DATA, IAG_POST_INC, IAG_PTR_ONE), 16'h0007, 1'b0, 1);
    chk("ptr1 lin", 16'h0008, regs_out.ptr[1]);
    load(IAG_REG_MODIFIER, 16'hFFFF);
    $display("test modulo done");
  endtask

  // Refused combinations leave nothing changed; legal flagged requests still answer.
  task automatic t_illegal();
    iag_req_t r;
    req(mk(IAG_SPACE_PROG, IAG_NO_UPD, IAG_PTR_ZERO), 16'h0000, 1'b1, 1);
    req(mk(IAG_SPACE_PROG, IAG_POST_INC, IAG_STACK_POINTER), 16'h0000, 1'b1, 1);
    r = mk(IAG_SPACE_PROG, IAG_POST_INC, IAG_PTR_ZERO);
    r.fetch_data = 1'b1;
    req(r, 16'h0000, 1'b1, 1);
    r.fetch_data = 1'b0;
    req(r, 16'h0002, 1'b0, 1);
    chk("space", {15'h0000, IAG_SPACE_PROG}, {15'h0000, rsp_out.space});
    r = mk(IAG_SPACE_DATA, IAG_POST_UPD_OFF, IAG_PTR_THREE);
    r.size = IAG_SIZE_BYTE;
    req(r, 16'h0000, 1'b1, 1);
    r = mk(IAG_SPACE_DATA, IAG_NO_UPD, IAG_PTR_TWO);
    r.dual_first = 1'b1;
    req(r, 16'h0000, 1'b1, 1);
    r = mk(IAG_SPACE_DATA, IAG_NO_UPD, IAG_PTR_ONE);
    r.dual_second = 1'b1;
    req(r, 16'h0000, 1'b1, 1);
    r.ptr = IAG_PTR_THREE;
    req(r, 16'h0110, 1'b0, 1);
    chk("on chip", 16'h0001, {15'h0000, rsp_out.on_chip_only});
    r = mk(IAG_SPACE_DATA, IAG_NO_UPD, IAG_PTR_ONE);
    r.shift_cnt = 1'b1;
    req(r, 16'h0000, 1'b1, 1);
    r.ptr = IAG_PTR_ZERO;
    req(r, 16'h0003, 1'b0, 1);
    $display("test illegal done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    miscompares = 0;
    checks = 0;
    nrst_in = 1'b0;
    wr_en_in = 1'b0;
    wr_sel_in = IAG_REG_OFFSET;
    wr_data_in = '0;
    repeat (3) @(negedge ref_clk_in);
    t_reset();
    t_modes();
    t_short();
    t_modulo();
    t_illegal();
    end_of_test();
  end

  // Watchdog: the whole run needs under a hundred cycles.
  initial begin
    #(40 * 5000);
    miscompares++;
    end_of_test();
  end
endmodule
